/* File: bench/rpc_port_paging_props.sv */
`timescale 1ns/1ps
`default_nettype none

module rpc_port_paging_props (
    input wire logic        clock,
    input wire logic        reset,
    input wire logic        acc_valid,
    input wire logic        acc_write,
    input wire logic        acc_local,
    input wire logic [1:0]  acc_port,
    input wire logic [6:0]  acc_dev_addr,
    input wire logic [7:0]  acc_offset,
    input wire logic [7:0]  acc_wdata,
    input wire logic [3:0]  cdr_lock,
    input wire logic        rsp_valid,
    input wire logic        rsp_hit,
    input wire logic [7:0]  rsp_rdata,
    input wire logic [3:0]  lock_status,
    input wire logic [3:0]  video_forward_enable,
    input wire logic [15:0] eq_setting
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (reset);

    sequence local_wr_s(ofs);
        acc_valid && acc_write && acc_local && acc_offset == ofs
            && acc_dev_addr == rpc_pkg::DEVICE_I2C_ADDRESS;
    endsequence
    sequence quiet_s;
        !acc_valid;
    endsequence
    // Status register stage lets lock trail a setting change
    property hold_p(int k);
        $changed(eq_setting[4*k +: 4]) |-> ##[0:3] !lock_status[k];
    endproperty

    rsp_follow_a: assert property (acc_valid |=> rsp_valid)
        else $error("request got no answer");
    reset_quiet_a: assert property (disable iff (1'b0)
        reset |=> !rsp_valid && lock_status == 4'h0 && video_forward_enable == 4'h0)
        else $error("outputs live after reset");
    disable_mask_a: assert property (local_wr_s(8'h0c) |-> ##2
        ((video_forward_enable | lock_status) & $past(acc_wdata[3:0], 2)) == 4'h0)
        else $error("disabled port still active");
    remote_ignore_a: assert property (
        (acc_valid && acc_write && !acc_local && acc_offset == 8'h0c) ##1 quiet_s
        |=> $stable(video_forward_enable))
        else $error("remote write moved disables");
    fwd_subset_a: assert property (local_wr_s(8'h20) ##1 quiet_s |=>
        (video_forward_enable & ~$past(acc_wdata[3:0], 2)) == 4'h0)
        else $error("forwarding without enable");
    lock_drop_a: assert property (
        (lock_status & ~(cdr_lock | $past(cdr_lock) | $past(cdr_lock, 2))) == 4'h0)
        else $error("lock held without link");
    lock_cause_a: assert property (
        (lock_status & ~$past(lock_status) & ~$past(cdr_lock)) == 4'h0)
        else $error("lock rose without link");
    eq_hold_a: assert property (hold_p(0))
        else $error("setting moved while locked");
endmodule

bind rpc_port_paging rpc_port_paging_props i_props (.clock, .reset, .acc_valid, .acc_write,
    .acc_local, .acc_port, .acc_dev_addr, .acc_offset, .acc_wdata, .cdr_lock, .rsp_valid,
    .rsp_hit, .rsp_rdata, .lock_status, .video_forward_enable, .eq_setting);

`default_nettype wire

/* File: bench/rpc_serializer_model.sv */
`timescale 1ns/1ps
`default_nettype none

module rpc_serializer_model #(
    parameter logic [15:0] NEED = 16'h4321
) (
    input  wire logic        clock,
    input  wire logic        reset,
    input  wire logic [3:0]  link_up,
    input  wire logic [15:0] eq_setting,
    output logic      [3:0]  cdr_lock
);
    always_ff @(posedge clock) begin
        for (int i = 0; i < 4; i++) begin
            cdr_lock[i] <= !reset && link_up[i] && eq_setting[4*i +: 4] >= NEED[4*i +: 4];
        end
    end
endmodule

`default_nettype wire

/* File: bench/test_rx_port_paging_control.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin num_errors++; \
    $display("MISMATCH %s exp %h got %h", nm, ex, got); end end

module test_rx_port_paging_control;
    localparam logic [6:0] DEV = rpc_pkg::DEVICE_I2C_ADDRESS;
    logic        clock = 1'b0, reset = 1'b1, acc_valid = 1'b0, acc_write = 1'b0;
    logic        acc_local = 1'b0, rsp_valid, rsp_hit;
    logic [1:0]  acc_port = 2'h0;
    logic [6:0]  acc_dev_addr = 7'h00;
    logic [7:0]  acc_offset = 8'h00, acc_wdata = 8'h00, rsp_rdata;
    logic [3:0]  link_up = 4'h0, cdr_lock, lock_status, video_forward_enable;
    logic [15:0] eq_setting;
    int          num_errors = 0, check_count = 0;

    always #2.5 clock = ~clock;

    rpc_port_paging #(.RELOCK_UNIT_CYCLES(4)) i_dut (.clock, .reset, .acc_valid, .acc_write,
        .acc_local, .acc_port, .acc_dev_addr, .acc_offset, .acc_wdata, .cdr_lock, .rsp_valid,
        .rsp_hit, .rsp_rdata, .lock_status, .video_forward_enable, .eq_setting);
    rpc_serializer_model i_ser (.clock, .reset, .link_up, .eq_setting, .cdr_lock);

    task automatic acc(input logic wr, lcl, input logic [1:0] prt, input logic [6:0] dev,
                       input logic [7:0] ofs, wd, exp_rd, input logic hit);
        @(posedge clock);
        acc_valid <= 1'b1;
        acc_write <= wr;
        acc_local <= lcl;
        acc_port <= prt;
        acc_dev_addr <= dev;
        acc_offset <= ofs;
        acc_wdata <= wd;
        @(posedge clock);
        acc_valid <= 1'b0;
        #1;
        `CHK("rsp_valid", 1'b1, rsp_valid)
        `CHK("rsp_hit", hit, rsp_hit)
        `CHK("rsp_rdata", exp_rd, rsp_rdata)
    endtask

    task automatic wr(input logic [7:0] ofs, wd);
        acc('1, '1, 2'h0, DEV, ofs, wd, 8'h00, '1);
    endtask

    task automatic rd(input logic [7:0] ofs, exp_rd);
        acc('0, '1, 2'h0, DEV, ofs, 8'h00, exp_rd, '1);
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic wait_lock(input logic [3:0] want);
        for (int n = 0; lock_status !== want; n++) begin
            if (n == 400) begin
                `CHK("lock_wait", want, lock_status)
                finish_test();
            end
            @(posedge clock);
            #1;
        end
    endtask

    task automatic t_reset();
        logic [7:0] ofs [7] = '{8'h0c, 8'h20, 8'h4c, 8'hf8, 8'hfb, 8'hd4, 8'hd5};
        logic [7:0] val [7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'hf0};
        `CHK("idle", 25'h0, {rsp_valid, lock_status, video_forward_enable, eq_setting})
        for (int i = 0; i < 7; i++) begin
            rd(ofs[i], val[i]);
        end
        $display("t_reset done");
    endtask

    task automatic t_paging();
        wr(8'h4c, 8'h02);
        wr(8'hd4, 8'h11);
        rd(8'h4c, 8'h02);
        wr(8'h4c, 8'h00);
        rd(8'hd4, 8'hff);
        acc('0, '0, 2'h3, DEV, 8'h4c, 8'h00, 8'h03, '1);
        acc('0, '0, 2'h2, DEV, 8'hd4, 8'h00, 8'h11, '1);
        $display("t_paging done");
    endtask

    task automatic t_direct();
        wr(8'hf9, 8'ha0);
        acc('1, '1, 2'h0, 7'h50, 8'hd4, 8'h22, 8'h00, '1);
        wr(8'h4c, 8'h01);
        rd(8'hd4, 8'h22);
        acc('0, '1, 2'h0, 7'h50, 8'hf9, 8'h00, 8'ha0, '1);
        acc('0, '1, 2'h0, 7'h51, 8'h0c, 8'h00, 8'h00, '0);
        rd(8'h77, 8'h00);
        $display("t_direct done");
    endtask

    task automatic t_fwd();
        wr(8'h20, 8'h03);
        @(posedge clock);
        #1;
        `CHK("fwd", 4'h3, video_forward_enable)
        acc('1, '1, 2'h0, 7'h50, 8'h20, 8'h0f, 8'h00, '1);
        acc('1, '0, 2'h1, DEV, 8'h0c, 8'h0f, 8'h00, '1);
        rd(8'h0c, 8'h00);
        `CHK("fwd", 4'hf, video_forward_enable)
        wr(8'h0c, 8'h05);
        @(posedge clock);
        #1;
        `CHK("fwd", 4'ha, video_forward_enable)
        rd(8'h4d, 8'ha0);
        rd(8'h0c, 8'h05);
        wr(8'h0c, 8'h00);
        $display("t_fwd done");
    endtask

    task automatic t_eq();
        wr(8'h0c, 8'h0f);
        @(posedge clock);
        link_up <= 4'hf;
        for (int p = 0; p < 4; p++) begin
            wr(8'h4c, 8'(p));
            wr(8'hd4, 8'h01);
        end
        `CHK("lock", 4'h0, lock_status)
        wr(8'h0c, 8'h00);
        wait_lock(4'hf);
        `CHK("eq", 16'h4321, eq_setting)
        @(posedge clock);
        link_up[1] <= 1'b0;
        wait_lock(4'hd);
        `CHK("eq1", 4'h3, eq_setting[7:4])
        @(posedge clock);
        link_up[1] <= 1'b1;
        wait_lock(4'hf);
        `CHK("eq1", 4'h3, eq_setting[7:4])
        repeat (12) @(posedge clock);
        #1;
        `CHK("eq", 16'h4331, eq_setting)
        `CHK("lock", 4'hf, lock_status)
        acc('0, '0, 2'h1, DEV, 8'hd3, 8'h00, 8'h03, '1);
        acc('1, '0, 2'h0, DEV, 8'hd2, 8'h01, 8'h00, '1);
        @(posedge clock);
        #1;
        `CHK("eq0", 4'h0, eq_setting[3:0])
        wait_lock(4'he);
        wait_lock(4'hf);
        `CHK("eq0", 4'h1, eq_setting[3:0])
        wr(8'h0c, 8'h08);
        @(posedge clock);
        #1;
        `CHK("lock", 4'h7, lock_status)
        $display("t_eq done");
    endtask

    initial begin
        repeat (3) @(posedge clock);
        reset <= 1'b0;
        @(posedge clock);
        #1;
        t_reset();
        t_paging();
        t_direct();
        t_fwd();
        t_eq();
        finish_test();
    end
endmodule

`default_nettype wire

/* File: pkg/rpc_eq_if.sv */
`timescale 1ns/1ps
`default_nettype none

interface rpc_eq_if;
    logic [3:0]      restart;
    logic [3:0]      port_disable;
    logic [3:0][7:0] range_cfg;
    logic [3:0][7:0] relock_cfg;
    logic [3:0]      locked;
    logic [3:0][3:0] setting;

    modport ctl (output restart, output port_disable, output range_cfg, output relock_cfg,
                 input locked, input setting);
    modport eq  (input restart, input port_disable, input range_cfg, input relock_cfg,
                 output locked, output setting);
endinterface

`default_nettype wire

/* File: pkg/rpc_pkg.sv */
package rpc_pkg;

    localparam int PORTS = 4;

    // Register offsets
    localparam logic [7:0] OFS_RX_INPUT_DISABLE_CONTROL = 8'h0c;
    localparam logic [7:0] OFS_VIDEO_FORWARDING_CONTROL = 8'h20;
    localparam logic [7:0] OFS_PORT_PAGE_SELECT         = 8'h4c;
    localparam logic [7:0] OFS_PORT_STATUS              = 8'h4d;
    localparam logic [7:0] OFS_EQ_CONTROL               = 8'hd2;
    localparam logic [7:0] OFS_EQ_STATUS                = 8'hd3;
    localparam logic [7:0] OFS_EQ_RELOCK                = 8'hd4;
    localparam logic [7:0] OFS_EQ_RANGE                 = 8'hd5;
    localparam logic [7:0] OFS_PORT0_DIRECT_I2C_ADDRESS = 8'hf8;
    localparam logic [7:0] OFS_PORT3_DIRECT_I2C_ADDRESS = 8'hfb;

    // Field positions
    localparam int EQ_RESTART_BIT  = 0;
    localparam int EQ_FLOOR_LSB    = 0;
    localparam int EQ_MAX_LSB      = 4;
    localparam int DIRECT_ADDR_LSB = 1;

    // Values after reset
    localparam logic [7:0] RST_RX_INPUT_DISABLE = 8'h00;
    localparam logic [7:0] RST_FORWARDING       = 8'h00;
    localparam logic [7:0] RST_DIRECT_ADDRESS   = 8'h00;
    localparam logic [7:0] RST_EQ_RANGE         = 8'hf0;
    localparam logic [7:0] RST_EQ_RELOCK        = 8'hff;
    localparam logic [3:0] RST_EQ_SETTING       = 4'h0;

    // Main I2C address of the hub; value is arbitrary
    localparam logic [6:0] DEVICE_I2C_ADDRESS = 7'h30;

    // Dwell time granule of the equalizer lock search
    localparam int CLOCK_PERIOD_NS    = 5;
    localparam int RELOCK_UNIT_NS     = 10240;
    localparam int RELOCK_UNIT_CYCLES = (RELOCK_UNIT_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
    localparam int DWELL_W            = 19;

    typedef enum logic [1:0] {
        RPC_EQ_OFF,
        RPC_EQ_SEARCH,
        RPC_EQ_LOCKED
    } rpc_eq_state_e;

endpackage

/* File: verilog/rpc_line_equalizer.sv */
`timescale 1ns/1ps
`default_nettype none

module rpc_line_equalizer #(
    parameter int RELOCK_UNIT_CYCLES = rpc_pkg::RELOCK_UNIT_CYCLES
) (
    input  wire logic       clock,
    input  wire logic       reset,
    input  wire logic [3:0] cdr_lock,
    rpc_eq_if.eq            eq_bus
);

    typedef struct packed {
        rpc_pkg::rpc_eq_state_e            st;
        logic [3:0]                        setting;
        logic [rpc_pkg::DWELL_W-1:0]       dwell;
    } rpc_port_s;

    typedef struct packed {
        rpc_port_s [3:0] p;
    } rpc_eq_s;

    rpc_eq_s r;
    rpc_eq_s next_r;

    logic [3:0]                  floor_v;
    logic [3:0]                  max_v;
    logic [rpc_pkg::DWELL_W-1:0] target;

    // One search engine per receive port
    // Independent port engines
    always_comb begin
        next_r  = r;
        floor_v = '0;
        max_v   = '0;
        target  = '0;
        for (int i = 0; i < rpc_pkg::PORTS; i++) begin
            floor_v = eq_bus.range_cfg[i][rpc_pkg::EQ_FLOOR_LSB +: 4];
            max_v   = eq_bus.range_cfg[i][rpc_pkg::EQ_MAX_LSB +: 4];
            // Zero relock field still dwells one granule
            target  = rpc_pkg::DWELL_W'(RELOCK_UNIT_CYCLES)
                    * ((eq_bus.relock_cfg[i] == 8'h00) ? rpc_pkg::DWELL_W'(1)
                                                       : rpc_pkg::DWELL_W'(eq_bus.relock_cfg[i]));
            if (eq_bus.port_disable[i]) begin
                next_r.p[i].st      = rpc_pkg::RPC_EQ_OFF;
                next_r.p[i].setting = floor_v;
                next_r.p[i].dwell   = '0;
            end else if (eq_bus.restart[i] || r.p[i].st == rpc_pkg::RPC_EQ_OFF) begin
                next_r.p[i].st      = rpc_pkg::RPC_EQ_SEARCH;
                next_r.p[i].setting = floor_v;
                next_r.p[i].dwell   = '0;
            end else begin
                unique case (r.p[i].st)
                    rpc_pkg::RPC_EQ_SEARCH: begin
                        if (r.p[i].dwell >= target - rpc_pkg::DWELL_W'(1)) begin
                            next_r.p[i].dwell = '0;
                            if (cdr_lock[i]) begin
                                next_r.p[i].st = rpc_pkg::RPC_EQ_LOCKED;
                            end else if (r.p[i].setting >= max_v) begin
                                next_r.p[i].setting = floor_v;
                            end else begin
                                next_r.p[i].setting = r.p[i].setting + 4'h1;
                            end
                        end else begin
                            next_r.p[i].dwell = r.p[i].dwell + rpc_pkg::DWELL_W'(1);
                        end
                    end
                    rpc_pkg::RPC_EQ_LOCKED: begin
                        if (!cdr_lock[i]) begin
                            next_r.p[i].st      = rpc_pkg::RPC_EQ_SEARCH;
                            next_r.p[i].dwell   = '0;
                            next_r.p[i].setting = (r.p[i].setting >= max_v) ? floor_v
                                                : r.p[i].setting + 4'h1;
                        end
                    end
                    default: begin
                        next_r.p[i].st = rpc_pkg::RPC_EQ_SEARCH;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            for (int i = 0; i < rpc_pkg::PORTS; i++) begin
                r.p[i].st      <= rpc_pkg::RPC_EQ_SEARCH;
                r.p[i].setting <= rpc_pkg::RST_EQ_SETTING;
                r.p[i].dwell   <= '0;
            end
        end else begin
            r <= next_r;
        end
    end

    always_comb begin
        for (int i = 0; i < rpc_pkg::PORTS; i++) begin
            eq_bus.locked[i]  = (r.p[i].st == rpc_pkg::RPC_EQ_LOCKED);
            eq_bus.setting[i] = r.p[i].setting;
        end
    end

endmodule

`default_nettype wire

/* File: verilog/rpc_port_paging.sv */
// Notes on behaviour
// - Four receive ports run side by side, each with its own control and status registers.
// - Register 0x0c holds one disable bit per receive input, bit i for port i.
// - Only the local host may write the disable bits; remote writes to 0x0c are dropped.
// - Register 0x4c picks which port's page the port-specific offsets reach.
// - A remote access on behalf of port p sees its own page select, which resets to p.
// - Registers 0xf8-0xfb hold a 7-bit direct address per port that reaches it without paging.
// - Accesses to a direct port address also reach every shared register.
// - Forwarding is off after reset until software sets the per-port bits of 0x20.
// - Each port's equalizer keeps watching the link and holds a working setting.
// - When a port loses lock its equalizer steps to the next setting and searches again until relock.
// - Equalizer control and status sit at port-specific offsets 0xd2 to 0xd5.
// - The search dwells a programmed period on each setting and stops while lock holds.
`timescale 1ns/1ps
`default_nettype none

module rpc_port_paging #(
    parameter int RELOCK_UNIT_CYCLES = rpc_pkg::RELOCK_UNIT_CYCLES
) (
    input  wire logic        clock,
    input  wire logic        reset,
    input  wire logic        acc_valid,
    input  wire logic        acc_write,
    input  wire logic        acc_local,
    input  wire logic [1:0]  acc_port,
    input  wire logic [6:0]  acc_dev_addr,
    input  wire logic [7:0]  acc_offset,
    input  wire logic [7:0]  acc_wdata,
    input  wire logic [3:0]  cdr_lock,
    output logic             rsp_valid,
    output logic             rsp_hit,
    output logic [7:0]       rsp_rdata,
    output logic [3:0]       lock_status,
    output logic [3:0]       video_forward_enable,
    output logic [15:0]      eq_setting
);

    typedef struct packed {
        logic [7:0]      rx_input_disable_control;
        logic [7:0]      video_forwarding_control;
        logic [4:0][1:0] port_page_select;
        logic [3:0][7:0] direct_i2c_address;
        logic [3:0][7:0] eq_range;
        logic [3:0][7:0] eq_relock;
        logic [3:0]      restart;
        logic            rsp_valid;
        logic            rsp_hit;
        logic [7:0]      rsp_rdata;
        logic [3:0]      lock_out;
        logic [3:0]      fwd_out;
    } rpc_regs_s;

    rpc_regs_s r;
    rpc_regs_s next_r;

    // Four remote views plus the local host's own view, kept last
    localparam int VIEWS = rpc_pkg::PORTS + 1;

    logic [2:0] view;
    logic       hit;
    logic [1:0] port;
    logic [7:0] rdata;

    // Engines run on their own; the page only picks which one a host sees
    rpc_eq_if eq_bus ();

    rpc_line_equalizer #(
        .RELOCK_UNIT_CYCLES (RELOCK_UNIT_CYCLES)
    ) u_equalizer (
        .clock    (clock),
        .reset    (reset),
        .cdr_lock (cdr_lock),
        .eq_bus   (eq_bus.eq)
    );

    always_comb begin
        next_r         = r;
        // Restart is a one-cycle strobe, so its control offset reads back zero
        next_r.restart = '0;
        // Local host uses view 4; remote port p uses view p
        // Per-origin page select
        view = acc_local ? 3'(rpc_pkg::PORTS) : {1'b0, acc_port};
        hit  = 1'b0;
        port = r.port_page_select[view];
        // Main address goes through the page
        if (acc_dev_addr == rpc_pkg::DEVICE_I2C_ADDRESS) begin
            hit = 1'b1;
        end
        // A zero address field means unused, so a fresh part never aliases
        // Direct per-port address bypasses paging
        for (int i = 0; i < rpc_pkg::PORTS; i++) begin
            if (r.direct_i2c_address[i][rpc_pkg::DIRECT_ADDR_LSB +: 7] != 7'h00 &&
                r.direct_i2c_address[i][rpc_pkg::DIRECT_ADDR_LSB +: 7] == acc_dev_addr) begin
                hit  = 1'b1;
                port = 2'(i);
            end
        end

        // Shared offsets decode alike for every address
        rdata = 8'h00;
        case (acc_offset)
            rpc_pkg::OFS_RX_INPUT_DISABLE_CONTROL: begin
                rdata = r.rx_input_disable_control;
            end
            rpc_pkg::OFS_VIDEO_FORWARDING_CONTROL: begin
                rdata = r.video_forwarding_control;
            end
            rpc_pkg::OFS_PORT_PAGE_SELECT: begin
                rdata = {6'h00, r.port_page_select[view]};
            end
            rpc_pkg::OFS_PORT_STATUS: begin
                rdata = {r.fwd_out, r.lock_out};
            end
            rpc_pkg::OFS_EQ_CONTROL: begin
                rdata = 8'h00;
            end
            rpc_pkg::OFS_EQ_STATUS: begin
                rdata = {4'h0, eq_bus.setting[port]};
            end
            rpc_pkg::OFS_EQ_RELOCK: begin
                rdata = r.eq_relock[port];
            end
            rpc_pkg::OFS_EQ_RANGE: begin
                rdata = r.eq_range[port];
            end
            default: begin
                if (acc_offset >= rpc_pkg::OFS_PORT0_DIRECT_I2C_ADDRESS &&
                    acc_offset <= rpc_pkg::OFS_PORT3_DIRECT_I2C_ADDRESS) begin
                    rdata = r.direct_i2c_address[acc_offset[1:0]];
                end
            end
        endcase

        // Unmatched addresses still answer, with hit low, so the host can NACK
        next_r.rsp_valid = acc_valid;
        next_r.rsp_hit   = acc_valid && hit;
        // Writes and misses return zero so stale data never leaks out
        next_r.rsp_rdata = (acc_valid && hit && !acc_write) ? rdata : 8'h00;

        if (acc_valid && hit && acc_write) begin
            case (acc_offset)
                rpc_pkg::OFS_RX_INPUT_DISABLE_CONTROL: begin
                    if (acc_local) begin
                        next_r.rx_input_disable_control = acc_wdata;
                    end
                end
                rpc_pkg::OFS_VIDEO_FORWARDING_CONTROL: begin
                    next_r.video_forwarding_control = acc_wdata;
                end
                // Each origin moves only its own page
                rpc_pkg::OFS_PORT_PAGE_SELECT: begin
                    next_r.port_page_select[view] = acc_wdata[1:0];
                end
                rpc_pkg::OFS_EQ_CONTROL: begin
                    next_r.restart[port] = acc_wdata[rpc_pkg::EQ_RESTART_BIT];
                end
                rpc_pkg::OFS_EQ_RELOCK: begin
                    next_r.eq_relock[port] = acc_wdata;
                end
                rpc_pkg::OFS_EQ_RANGE: begin
                    next_r.eq_range[port] = acc_wdata;
                end
                // Status and setting offsets are read only
                default: begin
                    if (acc_offset >= rpc_pkg::OFS_PORT0_DIRECT_I2C_ADDRESS &&
                        acc_offset <= rpc_pkg::OFS_PORT3_DIRECT_I2C_ADDRESS) begin
                        next_r.direct_i2c_address[acc_offset[1:0]] = acc_wdata;
                    end
                end
            endcase
        end

        // Masked here too, so a disable bit acts before the engine stops
        // Disabled port gives no lock and no video
        for (int i = 0; i < rpc_pkg::PORTS; i++) begin
            next_r.lock_out[i] = eq_bus.locked[i] && !r.rx_input_disable_control[i];
            next_r.fwd_out[i]  = r.video_forwarding_control[i] && !r.rx_input_disable_control[i];
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            r.rx_input_disable_control <= rpc_pkg::RST_RX_INPUT_DISABLE;
            r.video_forwarding_control <= rpc_pkg::RST_FORWARDING;
            // Each remote view starts on its own page; the local view starts on page 0
            for (int v = 0; v < VIEWS; v++) begin
                r.port_page_select[v] <= 2'(v);
            end
            // Direct addresses start unused, so only the main address answers
            for (int i = 0; i < rpc_pkg::PORTS; i++) begin
                r.direct_i2c_address[i] <= rpc_pkg::RST_DIRECT_ADDRESS;
                r.eq_range[i]           <= rpc_pkg::RST_EQ_RANGE;
                r.eq_relock[i]          <= rpc_pkg::RST_EQ_RELOCK;
            end
            r.restart   <= '0;
            r.rsp_valid <= 1'b0;
            r.rsp_hit   <= 1'b0;
            r.rsp_rdata <= 8'h00;
            r.lock_out  <= '0;
            r.fwd_out   <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign eq_bus.restart      = r.restart;
    assign eq_bus.port_disable = r.rx_input_disable_control[3:0];
    assign eq_bus.range_cfg    = r.eq_range;
    assign eq_bus.relock_cfg   = r.eq_relock;

    assign rsp_valid            = r.rsp_valid;
    assign rsp_hit              = r.rsp_hit;
    assign rsp_rdata            = r.rsp_rdata;
    assign lock_status          = r.lock_out;
    assign video_forward_enable = r.fwd_out;
    assign eq_setting           = eq_bus.setting;

endmodule

`default_nettype wire
